// ==== mmn_defines.svh ====
// Constants for the nibble-wide MAC-to-PHY interface block.
// Assumes inclusion by the package and the top module only.
// Behaviour
// - Frame enable rises with first preamble nibble.
// - Transmit bit 0 carries least significant bit.
// - Transmit outputs change on transmit clock rising.
// - Frame enable drops after final check nibble.
// - Collision synchronised into transmit clock domain.
// - Single flag octet suffices as lead-in.
// - Receive inputs sampled on receive clock rising.
// - Receive bit 0 holds least significant bit.
// - Receive error discards frame like CRC error.
// - Flag 5Dh starts frame; other lead-in accepted.
// - Carrier sense feeds deferral only, never framing.
// - External PHY select resets to zero.
// - Internal PHY answers management address zero.
// - Internal PHY isolated at reset until cleared.
// - External PHY select isolates internal PHY.
// - Isolated PHY ignores inputs, tristates outputs.
`ifndef MMN_DEFINES_SVH
`define MMN_DEFINES_SVH
`define MMN_FLAG_OCTET   8'h5d
`define MMN_CRC_INIT     32'hffffffff
`define MMN_CRC_RESIDUE  32'hdebb20e3
`define MMN_CRC_POLY     32'hedb88320
`define MMN_INT_PHY_ADDR 5'h00
`define MMN_EXTERNAL_PHY_SELECT_RST  1'b0
`define MMN_ISOLATE_RST  1'b1
`endif

// ==== mmn_pkg.sv ====
// Types and the frame check function of the interface block.
// Assumes the constants header is on the include path.
`include "mmn_defines.svh"
package mmn_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LO = 2'b01, TX_HI = 2'b10, TX_DROP = 2'b11} mmn_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_HUNT = 2'b01, RX_DATA = 2'b10} mmn_rx_state_t;
  typedef logic [3:0] mmn_nibble_t;

  function automatic logic [31:0] mmn_crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `MMN_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : mmn_crc_byte
endpackage : mmn_pkg

// ==== mmn_path_if.sv ====
// Transmit path signals between the top module and the transmit engine.
// Assumes every signal belongs to the transmit nibble clock domain.
`timescale 1ns/1ps
interface mmn_path_if;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_last;
  logic        tx_ready;
  logic        tx_col;
  logic        txen;
  logic [3:0]  txd;
  logic        tx_abort;
  modport eng (input tx_valid, tx_data, tx_last, tx_col, output tx_ready, txen, txd, tx_abort);
  modport top (output tx_valid, tx_data, tx_last, tx_col, input tx_ready, txen, txd, tx_abort);
endinterface : mmn_path_if

// ==== mmn_sync2.sv ====
// Two flip-flop synchroniser for one level.
// Assumes d may change at any time relative to clk.
`timescale 1ns/1ps
module mmn_sync2 (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : mmn_sync2

// ==== mmn_tx.sv ====
// Transmit engine: bytes in, nibbles out on the transmit nibble clock.
// Assumes tx_col is already synchronised to tx_nibble_clock.
`timescale 1ns/1ps
module mmn_tx (
  input  wire logic   tx_nibble_clock,
  input  wire logic   tx_rst_b,
  mmn_path_if.eng     p
);
  import mmn_pkg::*;
  mmn_tx_state_t st;
  logic [3:0]    hi;
  logic          last_q;
  logic          acc;

  assign p.tx_ready = (st == TX_DROP) || (!p.tx_col && (st == TX_IDLE || (st == TX_HI && !last_q)));
  assign acc        = p.tx_valid && p.tx_ready && (st != TX_DROP);

  always_ff @(posedge tx_nibble_clock or negedge tx_rst_b) begin
    if (!tx_rst_b) begin
      st <= TX_IDLE;
    end else begin
      case (st)
        TX_IDLE: if (acc) st <= TX_LO;
        TX_LO:   st <= p.tx_col ? (last_q ? TX_IDLE : TX_DROP) : TX_HI;
        TX_HI: begin
          if (p.tx_col) st <= last_q ? TX_IDLE : TX_DROP;
          else if (acc) st <= TX_LO;
          else st <= TX_IDLE;
        end
        TX_DROP: if (p.tx_valid && p.tx_last) st <= TX_IDLE;
        default: st <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge tx_nibble_clock or negedge tx_rst_b) begin
    if (!tx_rst_b) begin
      p.txen     <= 1'b0;
      p.txd      <= 4'h0;
      p.tx_abort <= 1'b0;
      hi         <= 4'h0;
      last_q     <= 1'b0;
    end else begin
      p.tx_abort <= 1'b0;
      if (acc) begin
        p.txen <= 1'b1;
        p.txd  <= p.tx_data[3:0];
        hi     <= p.tx_data[7:4];
        last_q <= p.tx_last;
      end else if (st == TX_LO && !p.tx_col) begin
        p.txd <= hi;
      end else begin
        p.txen <= 1'b0;
        p.txd  <= 4'h0;
        if (p.tx_col && (st == TX_LO || st == TX_HI)) p.tx_abort <= 1'b1;
      end
    end
  end

  sequence tail_s;
    p.txen ##1 p.txen ##1 !p.txen;
  endsequence

  property nib_order_p;
    logic [7:0] b;
    (acc, b = p.tx_data) |=> (p.txen && p.txd == b[3:0]) ##1 (p.txen && p.txd == b[7:4]);
  endproperty

  tx_nibble_order_a: assert property (@(posedge tx_nibble_clock) disable iff (!tx_rst_b || p.tx_col) nib_order_p)
    else $error("Transmit nibble order wrong.");
  tx_frame_end_a: assert property (@(posedge tx_nibble_clock) disable iff (!tx_rst_b || p.tx_col)
    (acc && p.tx_last) |=> tail_s)
    else $error("Frame enable did not drop after last nibble.");
  tx_col_abort_a: assert property (@(posedge tx_nibble_clock) disable iff (!tx_rst_b)
    (p.tx_col && (st == TX_LO || st == TX_HI)) |=> (!p.txen && p.tx_abort))
    else $error("Collision did not end the frame.");
endmodule : mmn_tx

// ==== mmn_mii_mac.sv ====
// MAC side of the nibble-wide PHY interface with internal PHY control.
// Assumes the PHY drives both nibble clocks and the receive pins
// synchronously to the receive nibble clock.
`timescale 1ns/1ps
`include "mmn_defines.svh"
module mmn_mii_mac (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        tx_nibble_clock,
  input  wire logic        rx_nibble_clock,
  output logic             tx_frame_enable,
  output logic [3:0]       tx_data_nibble,
  input  wire logic        collision_line,
  input  wire logic        carrier_sense_line,
  input  wire logic        rx_data_valid,
  input  wire logic        rx_error,
  input  wire mmn_pkg::mmn_nibble_t rx_data_nibble,
  input  wire logic        tx_byte_valid,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_byte_last,
  output logic             tx_byte_ready,
  output logic             tx_collision_abort,
  output logic [7:0]       rx_byte,
  output logic             rx_byte_valid,
  output logic             rx_frame_end,
  output logic             rx_frame_good,
  output logic             medium_busy,
  output logic             tx_in_progress,
  output logic             rx_frame_ok,
  output logic             rx_frame_bad,
  input  wire logic        external_phy_select_cfg,
  input  wire logic        isolate_set,
  input  wire logic        isolate_clear,
  input  wire logic [4:0]  mgmt_phy_addr,
  output logic             mgmt_addr_hit,
  output logic             external_phy_select,
  output logic             phy_isolate_bit,
  output logic             int_phy_mii_oe,
  output logic             int_phy_tp_oe,
  output logic             int_phy_input_en
);
  import mmn_pkg::*;

  // ******************************************************************
  // Reset release per link domain.
  // ******************************************************************

  logic tx_rst_b;
  logic rx_rst_b;

  mmn_sync2 u_tx_rst (
    .clk   (tx_nibble_clock),
    .rst_b (rst_b),
    .d     (1'b1),
    .q     (tx_rst_b)
  );

  mmn_sync2 u_rx_rst (
    .clk   (rx_nibble_clock),
    .rst_b (rst_b),
    .d     (1'b1),
    .q     (rx_rst_b)
  );

  // ******************************************************************
  // Transmit path.
  // ******************************************************************

  mmn_path_if pif ();

  assign pif.tx_valid = tx_byte_valid;
  assign pif.tx_data  = tx_byte;
  assign pif.tx_last  = tx_byte_last;

  mmn_sync2 u_col_sync (
    .clk   (tx_nibble_clock),
    .rst_b (tx_rst_b),
    .d     (collision_line),
    .q     (pif.tx_col)
  );

  mmn_tx u_tx (
    .tx_nibble_clock (tx_nibble_clock),
    .tx_rst_b        (tx_rst_b),
    .p               (pif.eng)
  );

  assign tx_frame_enable    = pif.txen;
  assign tx_data_nibble     = pif.txd;
  assign tx_byte_ready      = pif.tx_ready;
  assign tx_collision_abort = pif.tx_abort;

  // ******************************************************************
  // Receive sampling.
  // ******************************************************************

  logic          rxdv_q;
  logic          rxer_q;
  mmn_nibble_t   rxd_q;
  mmn_nibble_t   lo_q;
  logic          phase;
  logic [7:0]    pair;
  mmn_rx_state_t rx_st;
  logic          er_seen;
  logic [31:0]   crc;
  logic          done_tgl;
  logic          res_good;

  assign pair = {rxd_q, lo_q};

  always_ff @(posedge rx_nibble_clock or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      rxdv_q <= 1'b0;
      rxer_q <= 1'b0;
      rxd_q  <= 4'h0;
    end else begin
      rxdv_q <= rx_data_valid;
      rxer_q <= rx_error;
      rxd_q  <= rx_data_nibble;
    end
  end

  // ******************************************************************
  // Nibble pairing, aligned to the rise of data valid.
  // ******************************************************************

  always_ff @(posedge rx_nibble_clock or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      phase <= 1'b0;
      lo_q  <= 4'h0;
    end else begin
      phase <= rxdv_q ? ~phase : 1'b0;
      if (!phase) lo_q <= rxd_q;
    end
  end

  // ******************************************************************
  // Opening flag search and frame state.
  // ******************************************************************

  always_ff @(posedge rx_nibble_clock or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      rx_st <= RX_IDLE;
    end else if (!rxdv_q) begin
      rx_st <= RX_IDLE;
    end else begin
      case (rx_st)
        RX_IDLE, RX_HUNT: begin
          if (phase && pair == `MMN_FLAG_OCTET) rx_st <= RX_DATA;
          else rx_st <= RX_HUNT;
        end
        RX_DATA: rx_st <= RX_DATA;
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // ******************************************************************
  // Frame check and error tracking.
  // ******************************************************************

  always_ff @(posedge rx_nibble_clock or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      crc     <= `MMN_CRC_INIT;
      er_seen <= 1'b0;
    end else begin
      if (rx_st != RX_DATA) crc <= `MMN_CRC_INIT;
      else if (rxdv_q && phase) crc <= mmn_crc_byte(crc, pair);
      er_seen <= rxdv_q ? (er_seen | rxer_q) : 1'b0;
    end
  end

  // ******************************************************************
  // Receive byte stream and frame result.
  // ******************************************************************

  always_ff @(posedge rx_nibble_clock or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      rx_byte       <= 8'h00;
      rx_byte_valid <= 1'b0;
      rx_frame_end  <= 1'b0;
      rx_frame_good <= 1'b0;
      done_tgl      <= 1'b0;
      res_good      <= 1'b0;
    end else begin
      rx_byte_valid <= (rx_st == RX_DATA) && rxdv_q && phase;
      if ((rx_st == RX_DATA) && rxdv_q && phase) rx_byte <= pair;
      rx_frame_end  <= 1'b0;
      rx_frame_good <= 1'b0;
      if (rx_st == RX_DATA && !rxdv_q) begin
        rx_frame_end  <= 1'b1;
        rx_frame_good <= (crc == `MMN_CRC_RESIDUE) && !er_seen && !phase;
        res_good      <= (crc == `MMN_CRC_RESIDUE) && !er_seen && !phase;
        done_tgl      <= ~done_tgl;
      end
    end
  end

  // ******************************************************************
  // Crossings into the system clock domain.
  // ******************************************************************

  logic done_s;
  logic done_d;
  logic done_p;
  logic res_s;
  logic txen_s;

  mmn_sync2 u_crs_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (carrier_sense_line),
    .q     (medium_busy)
  );

  mmn_sync2 u_txen_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (pif.txen),
    .q     (txen_s)
  );

  mmn_sync2 u_done_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (done_tgl),
    .q     (done_s)
  );

  mmn_sync2 u_res_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (res_good),
    .q     (res_s)
  );

  assign tx_in_progress = txen_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_d      <= 1'b0;
      done_p      <= 1'b0;
      rx_frame_ok <= 1'b0;
      rx_frame_bad <= 1'b0;
    end else begin
      done_d       <= done_s;
      done_p       <= done_s ^ done_d;
      rx_frame_ok  <= done_p && res_s;
      rx_frame_bad <= done_p && !res_s;
    end
  end

  // ******************************************************************
  // Internal PHY selection, isolation and management address.
  // ******************************************************************

  logic iso_now;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      external_phy_select <= `MMN_EXTERNAL_PHY_SELECT_RST;
    end else begin
      external_phy_select <= external_phy_select_cfg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_isolate_bit <= `MMN_ISOLATE_RST;
    end else if (isolate_set) begin
      phy_isolate_bit <= 1'b1;
    end else if (isolate_clear) begin
      phy_isolate_bit <= 1'b0;
    end
  end

  assign iso_now = phy_isolate_bit || external_phy_select;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_phy_mii_oe   <= 1'b0;
      int_phy_tp_oe    <= 1'b0;
      int_phy_input_en <= 1'b0;
      mgmt_addr_hit    <= 1'b0;
    end else begin
      int_phy_mii_oe   <= !iso_now;
      int_phy_tp_oe    <= !iso_now;
      int_phy_input_en <= !iso_now;
      mgmt_addr_hit    <= (mgmt_phy_addr == `MMN_INT_PHY_ADDR);
    end
  end

  // ******************************************************************
  // Checks.
  // ******************************************************************

  logic [1:0] up_q;
  logic       err_mark;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_q <= 2'b00;
    end else begin
      up_q <= {up_q[0], 1'b1};
    end
  end

  always_ff @(posedge rx_nibble_clock or negedge rx_rst_b) begin
    if (!rx_rst_b) begin
      err_mark <= 1'b0;
    end else begin
      err_mark <= (rx_st == RX_DATA) && rxdv_q && (err_mark || rxer_q);
    end
  end

  sequence iso_cause_s;
    (phy_isolate_bit || external_phy_select);
  endsequence

  reset_defaults_a: assert property (@(posedge clk) disable iff (!rst_b)
    !up_q[0] |-> (!external_phy_select && phy_isolate_bit && !int_phy_mii_oe))
    else $error("Selection or isolation has the wrong reset value.");
  isolate_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (phy_isolate_bit && !isolate_clear) |=> phy_isolate_bit)
    else $error("Isolation left without a clear.");
  isolate_outputs_a: assert property (@(posedge clk) disable iff (!rst_b)
    iso_cause_s |=> (!int_phy_mii_oe && !int_phy_tp_oe && !int_phy_input_en))
    else $error("Isolated PHY still enabled.");
  ext_isolate_a: assert property (@(posedge clk) disable iff (!rst_b)
    external_phy_select |=> !int_phy_mii_oe)
    else $error("External selection did not isolate internal PHY.");
  crs_sync_a: assert property (@(posedge clk) disable iff (!rst_b)
    up_q[1] |-> (medium_busy == $past(carrier_sense_line, 2)))
    else $error("Carrier sense synchroniser latency wrong.");
  rx_flag_a: assert property (@(posedge rx_nibble_clock) disable iff (!rx_rst_b)
    (rx_st != RX_DATA && rxdv_q && phase && pair == `MMN_FLAG_OCTET) |=> (rx_st == RX_DATA))
    else $error("Opening flag missed.");
  rx_nibble_order_a: assert property (@(posedge rx_nibble_clock) disable iff (!rx_rst_b)
    rx_byte_valid |-> (rx_byte[7:4] == $past(rxd_q) && rx_byte[3:0] == $past(rxd_q, 2)))
    else $error("Receive nibble order wrong.");
  rx_err_drop_a: assert property (@(posedge rx_nibble_clock) disable iff (!rx_rst_b)
    (rx_st == RX_DATA && rxdv_q && rxer_q) ##1 (rxdv_q)[*1] ##1 !rxdv_q |=> (rx_frame_end && !rx_frame_good))
    else $error("Errored frame not discarded.");
  rx_err_any_a: assert property (@(posedge rx_nibble_clock) disable iff (!rx_rst_b)
    (rx_st == RX_DATA && !rxdv_q && err_mark) |=> (rx_frame_end && !rx_frame_good))
    else $error("Frame with a receive error was not discarded.");
  mgmt_match_a: assert property (@(posedge clk) disable iff (!rst_b)
    (mgmt_phy_addr == `MMN_INT_PHY_ADDR) |=> mgmt_addr_hit)
    else $error("Internal PHY address not recognised.");
endmodule : mmn_mii_mac

// ==== mmn_phy_model.sv ====
// PHY model: makes both nibble clocks, sends receive frames and drives carrier and collision.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/1ps
module mmn_phy_model (
  input  wire logic  tx_frame_enable,
  output logic       tx_nibble_clock,
  output logic       rx_nibble_clock,
  output logic       rx_data_valid,
  output logic       rx_error,
  output logic [3:0] rx_data_nibble,
  output logic       collision_line,
  output logic       carrier_sense_line
);
  logic active;
  logic crs_rx;
  logic crs_force;
  initial begin
    tx_nibble_clock = 1'b0;
    rx_nibble_clock = 1'b0;
    rx_data_valid   = 1'b0;
    rx_error        = 1'b0;
    rx_data_nibble  = 4'h0;
    collision_line  = 1'b0;
    active          = 1'b0;
    crs_rx          = 1'b0;
    crs_force       = 1'b0;
  end
  // ****************************************
  // Clocks, carrier and line activity.
  // ****************************************
  always #3 tx_nibble_clock = ~tx_nibble_clock;
  initial #1.3 forever #3 rx_nibble_clock = ~rx_nibble_clock;
  assign carrier_sense_line = (active & crs_rx) | tx_frame_enable | collision_line | crs_force;
  always @(posedge rx_nibble_clock) if (!active) rx_data_nibble <= ~rx_data_nibble;

  task automatic drive(input logic col, input logic crs);
    #1.1;
    collision_line = col;
    crs_force      = crs;
  endtask : drive

  task automatic send(input logic [7:0] b[$], input int err_at, input logic crs_on);
    crs_rx = crs_on;
    for (int i = 0; i < 2 * b.size(); i++) begin
      @(posedge rx_nibble_clock);
      active = 1'b1;
      rx_data_valid  <= 1'b1;
      rx_error       <= (i == err_at);
      rx_data_nibble <= i[0] ? b[i / 2][7:4] : b[i / 2][3:0];
    end
    @(posedge rx_nibble_clock);
    rx_data_valid <= 1'b0;
    rx_error      <= 1'b0;
    active = 1'b0;
  endtask : send
endmodule : mmn_phy_model

// ==== tb_mii_mac_nibble_interface.sv ====
// Self-checking bench of the nibble-wide MAC interface block.
// Assumes the PHY model file and the design files are compiled first.
`timescale 1ns/1ps
module tb_mii_mac_nibble_interface;
  import mmn_pkg::*;
  logic        clk, rst_b, tx_nibble_clock, rx_nibble_clock, tx_frame_enable, collision_line;
  logic        carrier_sense_line, rx_data_valid, rx_error, tx_byte_valid, tx_byte_last, tx_byte_ready;
  logic        tx_collision_abort, rx_byte_valid, rx_frame_end, rx_frame_good, medium_busy, tx_in_progress;
  logic        rx_frame_ok, rx_frame_bad, external_phy_select_cfg, isolate_set, isolate_clear, mgmt_addr_hit;
  logic        external_phy_select, phy_isolate_bit, int_phy_mii_oe, int_phy_tp_oe, int_phy_input_en;
  logic [3:0]  tx_data_nibble;
  mmn_nibble_t rx_data_nibble;
  logic [7:0]  tx_byte, rx_byte;
  logic [4:0]  mgmt_phy_addr;
  logic [3:0]  got_n[$];
  logic [7:0]  got_b[$];
  int          n_end, n_good, n_ok, n_bad, n_abort, n_txp, cyc, miscompares, n_checks;

  mmn_mii_mac i_mmn_mii_mac (.clk, .rst_b, .tx_nibble_clock, .rx_nibble_clock, .tx_frame_enable,
    .tx_data_nibble, .collision_line, .carrier_sense_line, .rx_data_valid, .rx_error, .rx_data_nibble,
    .tx_byte_valid, .tx_byte, .tx_byte_last, .tx_byte_ready, .tx_collision_abort, .rx_byte, .rx_byte_valid,
    .rx_frame_end, .rx_frame_good, .medium_busy, .tx_in_progress, .rx_frame_ok, .rx_frame_bad, .external_phy_select_cfg,
    .isolate_set, .isolate_clear, .mgmt_phy_addr, .mgmt_addr_hit, .external_phy_select, .phy_isolate_bit,
    .int_phy_mii_oe, .int_phy_tp_oe, .int_phy_input_en);
  mmn_phy_model i_mmn_phy_model (.tx_frame_enable, .tx_nibble_clock, .rx_nibble_clock, .rx_data_valid,
    .rx_error, .rx_data_nibble, .collision_line, .carrier_sense_line);

  // ****************************************
  // Clock, monitors and helpers.
  // ****************************************
  always #20 clk = ~clk;
  always @(posedge tx_nibble_clock) begin
    if (tx_frame_enable === 1'b1) got_n.push_back(tx_data_nibble);
    if (tx_collision_abort === 1'b1) n_abort++;
  end
  always @(posedge rx_nibble_clock) begin
    if (rx_byte_valid === 1'b1) got_b.push_back(rx_byte);
    if (rx_frame_end === 1'b1) n_end++;
    if (rx_frame_end === 1'b1 && rx_frame_good === 1'b1) n_good++;
  end
  always @(posedge clk) begin
    cyc++;
    if (tx_in_progress === 1'b1) n_txp++;
    if (rx_frame_ok === 1'b1) n_ok++;
    if (rx_frame_bad === 1'b1) n_bad++;
    if (cyc == 5000) begin
      miscompares++;
      summarize();
    end
  end

  function automatic logic [31:0] fcs_of(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hffffffff;
    foreach (b[i]) begin
      c ^= {24'h000000, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    return ~c;
  endfunction : fcs_of

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_bit(input logic g, input logic e);
    chk_val({7'h00, g}, {7'h00, e});
  endtask : chk_bit
  task automatic summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic do_reset();
    rst_b <= 1'b0;
    tick(5);
    rst_b <= 1'b1;
    tick(3);
  endtask : do_reset
  task automatic cfg(input logic ext, input logic set, input logic clr, input logic iso);
    external_phy_select_cfg   <= ext;
    isolate_set   <= set;
    isolate_clear <= clr;
    tick(1);
    isolate_set   <= 1'b0;
    isolate_clear <= 1'b0;
    tick(3);
    chk_bit(external_phy_select, ext);
    chk_bit(phy_isolate_bit, iso);
    chk_bit(int_phy_mii_oe, !iso && !ext);
    chk_bit(int_phy_tp_oe, !iso && !ext);
    chk_bit(int_phy_input_en, !iso && !ext);
  endtask : cfg
  task automatic mgmt(input logic [4:0] a);
    mgmt_phy_addr <= a;
    tick(2);
    chk_bit(mgmt_addr_hit, a == 5'h00);
  endtask : mgmt

  task automatic tx_send(input int n, input int col_at);
    logic [7:0] b[$];
    int a0, w;
    b = '{8'h55, 8'h55, 8'h5d};
    while (b.size() < n) b.push_back(8'($urandom));
    got_n = {};
    a0 = n_abort;
    @(posedge tx_nibble_clock);
    for (int k = 0; k < n; k++) begin
      tx_byte_valid <= 1'b1;
      tx_byte       <= b[k];
      tx_byte_last  <= (k == n - 1);
      w = 0;
      do begin
        @(negedge tx_nibble_clock);
        w++;
      end while (tx_byte_ready !== 1'b1 && w < 50);
      chk_bit(w < 50, 1'b1);
      @(posedge tx_nibble_clock);
      if (k == col_at) fork
        begin
          i_mmn_phy_model.drive(1'b1, 1'b0);
          #30 i_mmn_phy_model.drive(1'b0, 1'b0);
        end
      join_none
    end
    tx_byte_valid <= 1'b0;
    tx_byte_last  <= 1'b0;
    repeat (12) @(posedge tx_nibble_clock);
    chk_bit(tx_frame_enable, 1'b0);
    if (col_at < 0) begin
      chk_val(8'(got_n.size()), 8'(2 * n));
      foreach (b[i]) chk_val({got_n[2 * i + 1], got_n[2 * i]}, b[i]);
    end else begin
      chk_bit(got_n.size() < 2 * n, 1'b1);
      chk_val(8'(n_abort - a0), 8'h01);
    end
  endtask : tx_send

  task automatic rx_send(input int lead, input int n, input int err_at, input logic bad, input logic crs_on);
    logic [7:0] f[$];
    logic [7:0] d[$];
    logic [7:0] r;
    logic [31:0] c;
    int e0, g0, k0, b0;
    logic ok;
    repeat (lead) begin
      r = 8'($urandom);
      f.push_back(r == 8'h5d ? 8'h55 : r);
    end
    f.push_back(8'h5d);
    repeat (n) d.push_back(8'($urandom));
    c = fcs_of(d);
    for (int i = 0; i < 4; i++) d.push_back(c[8 * i +: 8]);
    if (bad) d[0] ^= 8'h01;
    foreach (d[i]) f.push_back(d[i]);
    ok = !bad && err_at < 0;
    e0 = n_end;
    g0 = n_good;
    k0 = n_ok;
    b0 = n_bad;
    got_b = {};
    i_mmn_phy_model.send(f, err_at, crs_on);
    tick(30);
    chk_val(8'(n_end - e0), 8'h01);
    chk_val(8'(n_good - g0), {7'h00, ok});
    chk_val(8'(n_ok - k0), {7'h00, ok});
    chk_val(8'(n_bad - b0), {7'h00, !ok});
    if (err_at < 0) begin
      chk_bit(got_b.size() >= d.size(), 1'b1);
      if (got_b.size() >= d.size()) foreach (d[i]) chk_val(got_b[got_b.size() - d.size() + i], d[i]);
    end
  endtask : rx_send

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    tx_byte_valid = 1'b0;
    tx_byte = 8'h00;
    tx_byte_last = 1'b0;
    external_phy_select_cfg = 1'b0;
    isolate_set = 1'b0;
    isolate_clear = 1'b0;
    mgmt_phy_addr = 5'h00;
    void'($urandom(2));
    do_reset();
    cfg(1'b0, 1'b0, 1'b0, 1'b1);
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    cfg(1'b0, 1'b1, 1'b1, 1'b1);
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    mgmt(5'h00);
    mgmt(5'h01);
    mgmt(5'h10);
    repeat (3) mgmt(5'($urandom));
    tx_send(4, -1);
    tx_send(24, -1);
    tx_send(12, 5);
    tx_send(6, -1);
    rx_send(0, 20, -1, 1'b0, 1'b1);
    rx_send(3, 1, -1, 1'b0, 1'b1);
    rx_send(2, 30, 15, 1'b0, 1'b1);
    rx_send(2, 6, 24, 1'b0, 1'b1);
    rx_send(1, 10, -1, 1'b1, 1'b1);
    rx_send(0, 8, -1, 1'b0, 1'b0);
    chk_bit(tx_in_progress, 1'b0);
    chk_bit(n_txp > 0, 1'b1);
    tick(1);
    i_mmn_phy_model.drive(1'b0, 1'b1);
    repeat (2) @(negedge clk);
    chk_bit(medium_busy, 1'b0);
    repeat (3) @(negedge clk);
    chk_bit(medium_busy, 1'b1);
    i_mmn_phy_model.drive(1'b0, 1'b0);
    repeat (5) @(negedge clk);
    chk_bit(medium_busy, 1'b0);
    tick(1);
    do_reset();
    cfg(1'b0, 1'b0, 1'b0, 1'b1);
    summarize();
  end
endmodule : tb_mii_mac_nibble_interface
